/* File: include/hbe_pkg.sv */
// Purpose: shared constants for the burst write engine and its bus host
// Assumes: one clock (mclk), synchronous active-high reset
// Notes:   register addresses are full 32-bit byte addresses
// Operation
// - trigger write requests bus, ten writes
// - four byte address registers, byte0 high
// - low two address bits are ignored
// - all ten writes hit same address
// - firmware loads address before trigger
// - done flag is bit 0, resets 0
// - done set before bus is released
// - no interrupt on run completion
// - write 0 clears done, 1 ignored
// - poll done, clear before next trigger
// - done cleared here, read status bit 7
// - write data value is don't care
// - only bus error detected; ignored as slave
// - error while mastering sets log bit 6
// - log bit 6 blocks mastering until cleared
// - error log read-only byte, bits 0-5 others
package hbe_pkg;
    // device register map
    localparam logic [31:0] ADDR_BYTE0  = 32'hF0830000;
    localparam logic [31:0] ADDR_BYTE1  = 32'hF0830004;
    localparam logic [31:0] ADDR_BYTE2  = 32'hF0830008;
    localparam logic [31:0] ADDR_BYTE3  = 32'hF083000C;
    localparam logic [31:0] ADDR_TRIG   = 32'hF0830010;
    localparam logic [31:0] ADDR_DONE   = 32'hF0830020;
    localparam logic [31:0] ADDR_STATUS = 32'hF082F020;
    localparam logic [31:0] ADDR_ERRLOG = 32'h0F02F040;
    localparam int          DONE_BIT    = 0;
    localparam int          STAT_DONE   = 7;
    localparam int          ERR_BURST   = 6;
    localparam logic [3:0]  BURST_LEN   = 4'hA;
    localparam logic [1:0]  BYTE_OFS    = 2'h0;
    // host register offsets on ahb
    localparam logic [7:0]  H_CTRL      = 8'h00;
    localparam logic [7:0]  H_TADDR     = 8'h04;
    localparam logic [7:0]  H_STAT      = 8'h08;
    localparam logic [7:0]  H_ISTAT     = 8'h0C;
    localparam logic [7:0]  H_IMASK     = 8'h10;
    localparam logic [7:0]  H_WCNT      = 8'h14;
    localparam logic [7:0]  H_LADDR     = 8'h18;
    localparam logic [7:0]  H_ERRLOG    = 8'h1C;
    localparam int          CTRL_START  = 0;
    localparam int          CTRL_ERRINJ = 1;
    localparam int          IRQ_DONE    = 0;
    localparam int          IRQ_ERR     = 1;
    localparam logic [31:0] RST_WORD    = 32'h00000000;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
endpackage : hbe_pkg

/* File: include/hbe_if.sv */
`timescale 1ns/1ps
// Purpose: register port and system bus between engine and host
// Assumes: both ends on mclk
// Notes:   no clocking block; the bench joins the ends
interface hbe_if (
    input wire logic mclk,    // system clock
    input wire logic rst      // synchronous reset
);
    logic        regWrite;    // register write pulse
    logic        regRead;     // register read pulse
    logic [31:0] regAddr;     // register byte address
    logic [7:0]  regWdata;    // register write byte
    logic [7:0]  regRdata;    // register read byte
    logic        regAck;      // access done pulse
    logic        busReq;      // engine wants the bus
    logic        busGrant;    // arbiter grants the bus
    logic        busWrite;    // one write per cycle
    logic [31:0] busAddr;     // write word address
    logic [31:0] busWdata;    // write data
    logic        busError;    // bus error on this write

    modport dev (input mclk, rst, regWrite, regRead, regAddr, regWdata, busGrant, busError,
                 output regRdata, regAck, busReq, busWrite, busAddr, busWdata);
    modport ctl (input mclk, rst, regRdata, regAck, busReq, busWrite, busAddr, busWdata,
                 output regWrite, regRead, regAddr, regWdata, busGrant, busError);
endinterface : hbe_if

/* File: design/hbe_burst_engine.sv */
`timescale 1ns/1ps
// Purpose: burst write engine, ten same-address writes per trigger
// Assumes: one register access at a time, answered by regAck
// Notes:   other masters' error bits come in on masterErr
module hbe_burst_engine (
    hbe_if.dev              link,       // register port and system bus
    input  wire logic [5:0] masterErr,  // error pulses of other masters
    input  wire logic [7:0] errClear,   // software clear of error log bits
    output logic            running     // run in progress
);
    typedef enum {E_IDLE, E_REQ, E_WRITE, E_FIN} hbe_eng_st_t;
    typedef struct packed {
        hbe_eng_st_t st;
        logic [31:0] addr;
        logic [3:0]  count;
        logic        done;
        logic [7:0]  errLog;
        logic        req;
        logic        wr;
        logic [7:0]  rdata;
        logic        ack;
    } hbe_eng_t;

    hbe_eng_t s_reg, s_next;

    // byte-wide decode of the address write ports
    function automatic logic [2:0] addrSel(input logic [31:0] a);
        case (a)
            hbe_pkg::ADDR_BYTE0: addrSel = 3'h4;
            hbe_pkg::ADDR_BYTE1: addrSel = 3'h5;
            hbe_pkg::ADDR_BYTE2: addrSel = 3'h6;
            hbe_pkg::ADDR_BYTE3: addrSel = 3'h7;
            default:             addrSel = 3'h0;
        endcase
    endfunction : addrSel

    logic       wrEv;
    logic       rdEv;
    logic [2:0] sel;
    logic       errHit;
    logic [7:0] errSet;

    // next state
    always_comb begin
        s_next = s_reg;
        wrEv   = link.regWrite;
        rdEv   = link.regRead;
        sel    = addrSel(link.regAddr);
        errHit = 1'b0;
        s_next.ack = wrEv | rdEv;
        // address bytes, byte 0 is the high byte
        if (wrEv && sel[2]) begin
            case (sel[1:0])
                2'h0:    s_next.addr[31:24] = link.regWdata;
                2'h1:    s_next.addr[23:16] = link.regWdata;
                2'h2:    s_next.addr[15:8]  = link.regWdata;
                default: s_next.addr[7:0]   = link.regWdata;
            endcase
        end
        // reads: status bit 7 shows done, error log, else zero
        if (rdEv) begin
            case (link.regAddr)
                hbe_pkg::ADDR_STATUS: s_next.rdata = {s_reg.done, 7'h00};
                hbe_pkg::ADDR_ERRLOG: s_next.rdata = s_reg.errLog;
                default:              s_next.rdata = hbe_pkg::RST_BYTE;
            endcase
        end
        // done clear: only a written 0 clears
        if (wrEv && link.regAddr == hbe_pkg::ADDR_DONE && !link.regWdata[hbe_pkg::DONE_BIT]) begin
            s_next.done = 1'b0;
        end
        // run sequencer
        case (s_reg.st)
            E_IDLE: begin
                // any value triggers; blocked while log bit 6 set
                if (wrEv && link.regAddr == hbe_pkg::ADDR_TRIG && !s_reg.errLog[hbe_pkg::ERR_BURST]) begin
                    s_next.st  = E_REQ;
                    s_next.req = 1'b1;
                end
            end
            E_REQ: begin
                if (link.busGrant) begin
                    s_next.st    = E_WRITE;
                    s_next.wr    = 1'b1;
                    s_next.count = 4'h0;
                end
            end
            E_WRITE: begin
                if (link.busError) begin
                    errHit       = 1'b1;
                    s_next.wr    = 1'b0;
                    s_next.req   = 1'b0;
                    s_next.st    = E_IDLE;
                end else if (s_reg.count == hbe_pkg::BURST_LEN - 4'h1) begin
                    s_next.wr    = 1'b0;
                    s_next.done  = 1'b1;
                    s_next.st    = E_FIN;
                end else begin
                    s_next.count = s_reg.count + 4'h1;
                end
            end
            E_FIN: begin
                s_next.req = 1'b0;
                s_next.st  = E_IDLE;
            end
            default: s_next.st = E_IDLE;
        endcase
        // error log: set wins over clear; bus errors as slave ignored
        errSet        = {1'b0, errHit, masterErr};
        s_next.errLog = ((s_reg.errLog & ~errClear) | errSet) & 8'h7F;
        if (link.rst) begin
            s_next = '{st: E_IDLE, addr: hbe_pkg::RST_WORD, count: 4'h0, done: 1'b0,
                       errLog: hbe_pkg::RST_BYTE, req: 1'b0, wr: 1'b0,
                       rdata: hbe_pkg::RST_BYTE, ack: 1'b0};
        end
    end

    // state register
    always_ff @(posedge link.mclk) begin
        s_reg <= s_next;
    end

    // outputs; trigger while busy falls through E_REQ..E_FIN untouched
    assign link.regRdata = s_reg.rdata;
    assign link.regAck   = s_reg.ack;
    assign link.busReq   = s_reg.req;
    assign link.busWrite = s_reg.wr;
    assign link.busAddr  = {s_reg.addr[31:2], hbe_pkg::BYTE_OFS};
    assign link.busWdata = {28'h0000000, s_reg.count};
    assign running       = (s_reg.st != E_IDLE);
endmodule : hbe_burst_engine

/* File: design/hbe_bus_host.sv */
`timescale 1ns/1ps
// Purpose: ahb-lite controlled host: programs engine, arbitrates, sinks writes
// Assumes: single-word ahb transfers, response always okay
// Notes:   zero wait state slave; irq is a level
module hbe_bus_host (
    hbe_if.ctl                link,      // register port and system bus
    input  wire logic         hsel,      // ahb select
    input  wire logic [31:0]  haddr,     // ahb address
    input  wire logic [1:0]   htrans,    // ahb transfer type
    input  wire logic         hwrite,    // ahb write
    input  wire logic [2:0]   hsize,     // ahb size, word only
    input  wire logic [31:0]  hwdata,    // ahb write data
    input  wire logic         hready,    // ahb bus ready
    output logic [31:0]       hrdata,    // ahb read data
    output logic              hreadyout, // ahb slave ready
    output logic              hresp,     // ahb response
    output logic              irq        // level interrupt
);
    typedef enum {H_IDLE, H_ADDR, H_TRIG, H_POLL, H_ERR, H_CLR} hbe_host_st_t;
    typedef struct packed {
        hbe_host_st_t st;
        logic [1:0]   step;
        logic         pend;
        logic         rw;
        logic         rd;
        logic [31:0]  ra;
        logic [7:0]   wd;
        logic [31:0]  taddr;
        logic         errInj;
        logic [1:0]   iStat;
        logic [1:0]   iMask;
        logic [7:0]   wCnt;
        logic [31:0]  lAddr;
        logic [7:0]   errLog;
        logic         grant;
        logic         dSel;
        logic         dWrite;
        logic [7:0]   dAddr;
    } hbe_host_t;

    hbe_host_t s_reg, s_next;
    logic [1:0] iSet;
    logic       berr;

    // issue one register access to the engine
    function automatic hbe_host_t issue(input hbe_host_t s, input logic w, input logic [31:0] a,
                                       input logic [7:0] d);
        issue      = s;
        issue.rw   = w;
        issue.rd   = !w;
        issue.ra   = a;
        issue.wd   = d;
        issue.pend = 1'b1;
        return issue;
    endfunction : issue

    assign berr = s_reg.errInj & link.busWrite;

    // next state
    always_comb begin
        s_next    = s_reg;
        iSet      = 2'b00;
        s_next.rw = 1'b0;
        s_next.rd = 1'b0;
        // ahb address phase capture
        s_next.dSel   = hsel & htrans[1] & hready;
        s_next.dWrite = hwrite;
        s_next.dAddr  = haddr[7:0];
        // arbiter grants while requested; sink counts writes
        s_next.grant = link.busReq;
        if (link.busWrite) begin
            s_next.wCnt  = s_reg.wCnt + 8'h01;
            s_next.lAddr = link.busAddr;
        end
        if (berr) begin
            s_next.errInj = 1'b0;
        end
        // firmware sequence
        if (!s_reg.pend || link.regAck) begin
            s_next.pend = 1'b0;
            case (s_reg.st)
                H_IDLE: ;
                H_ADDR: begin
                    // load all four bytes first
                    s_next = issue(s_next, 1'b1, hbe_pkg::ADDR_BYTE0 + {28'h0, s_reg.step, 2'b00},
                                   8'(s_reg.taddr >> (5'd24 - {s_reg.step, 3'b000})));
                    s_next.step = s_reg.step + 2'h1;
                    if (s_reg.step == 2'h3) s_next.st = H_TRIG;
                end
                H_TRIG: begin
                    s_next = issue(s_next, 1'b1, hbe_pkg::ADDR_TRIG, 8'hFF);
                    s_next.st = H_POLL;
                end
                H_POLL: begin
                    // only a status read answer counts; read data left from an earlier run is stale
                    if (s_reg.pend && s_reg.ra == hbe_pkg::ADDR_STATUS && link.regRdata[hbe_pkg::STAT_DONE]) begin
                        s_next = issue(s_next, 1'b1, hbe_pkg::ADDR_DONE, 8'h00);
                        s_next.st = H_CLR;
                    end else begin
                        s_next = issue(s_next, 1'b0, hbe_pkg::ADDR_ERRLOG, 8'h00);
                        s_next.st = H_ERR;
                    end
                end
                H_ERR: begin
                    s_next.errLog = link.regRdata;
                    if (link.regRdata[hbe_pkg::ERR_BURST]) begin
                        iSet[hbe_pkg::IRQ_ERR] = 1'b1;
                        s_next.st = H_IDLE;
                    end else begin
                        s_next = issue(s_next, 1'b0, hbe_pkg::ADDR_STATUS, 8'h00);
                        s_next.st = H_POLL;
                    end
                end
                H_CLR: begin
                    iSet[hbe_pkg::IRQ_DONE] = 1'b1;
                    s_next.st = H_IDLE;
                end
                default: s_next.st = H_IDLE;
            endcase
        end
        // ahb data phase writes
        if (s_reg.dSel && s_reg.dWrite) begin
            case (s_reg.dAddr)
                hbe_pkg::H_CTRL: begin
                    if (hwdata[hbe_pkg::CTRL_START] && s_reg.st == H_IDLE) begin
                        s_next.st   = H_ADDR;
                        s_next.step = 2'h0;
                    end
                    if (hwdata[hbe_pkg::CTRL_ERRINJ]) s_next.errInj = 1'b1;
                end
                hbe_pkg::H_TADDR: s_next.taddr = hwdata;
                hbe_pkg::H_IMASK: s_next.iMask = hwdata[1:0];
                hbe_pkg::H_WCNT:  s_next.wCnt  = 8'h00;
                default: ;
            endcase
        end
        // sticky status, set wins over write-one clear
        if (s_reg.dSel && s_reg.dWrite && s_reg.dAddr == hbe_pkg::H_ISTAT) begin
            s_next.iStat = (s_reg.iStat & ~hwdata[1:0]) | iSet;
        end else begin
            s_next.iStat = s_reg.iStat | iSet;
        end
        if (link.rst) begin
            s_next = '{st: H_IDLE, step: 2'h0, pend: 1'b0, rw: 1'b0, rd: 1'b0,
                       ra: hbe_pkg::RST_WORD, wd: hbe_pkg::RST_BYTE, taddr: hbe_pkg::RST_WORD,
                       errInj: 1'b0, iStat: 2'b00, iMask: 2'b00, wCnt: hbe_pkg::RST_BYTE,
                       lAddr: hbe_pkg::RST_WORD, errLog: hbe_pkg::RST_BYTE, grant: 1'b0,
                       dSel: 1'b0, dWrite: 1'b0, dAddr: hbe_pkg::RST_BYTE};
        end
    end

    // state register
    always_ff @(posedge link.mclk) begin
        s_reg <= s_next;
    end

    // ahb read mux from registered state
    always_comb begin
        case (s_reg.dAddr)
            hbe_pkg::H_CTRL:   hrdata = {30'h0, s_reg.errInj, 1'b0};
            hbe_pkg::H_TADDR:  hrdata = s_reg.taddr;
            hbe_pkg::H_STAT:   hrdata = {31'h0, s_reg.st != H_IDLE};
            hbe_pkg::H_ISTAT:  hrdata = {30'h0, s_reg.iStat};
            hbe_pkg::H_IMASK:  hrdata = {30'h0, s_reg.iMask};
            hbe_pkg::H_WCNT:   hrdata = {24'h0, s_reg.wCnt};
            hbe_pkg::H_LADDR:  hrdata = s_reg.lAddr;
            hbe_pkg::H_ERRLOG: hrdata = {24'h0, s_reg.errLog};
            default:           hrdata = hbe_pkg::RST_WORD;
        endcase
    end

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign irq           = |(s_reg.iStat & s_reg.iMask);
    assign link.regWrite = s_reg.rw;
    assign link.regRead  = s_reg.rd;
    assign link.regAddr  = s_reg.ra;
    assign link.regWdata = s_reg.wd;
    assign link.busGrant = s_reg.grant;
    assign link.busError = berr;
endmodule : hbe_bus_host

/* File: tb/hbe_asserts.sv */
// Purpose: link checks between burst engine and bus host
// Assumes: one clock, sync active-high reset
// Notes:   sees only the interface signals
`timescale 1ns/1ps
module hbe_asserts (
    input wire logic        mclk,     // system clock
    input wire logic        rst,      // sync reset
    input wire logic        regWrite, // register write pulse
    input wire logic        regRead,  // register read pulse
    input wire logic [31:0] regAddr,  // register address
    input wire logic [7:0]  regWdata, // register write byte
    input wire logic [7:0]  regRdata, // register read byte
    input wire logic        busReq,   // engine bus request
    input wire logic        busGrant, // bus grant
    input wire logic        busWrite, // write cycle
    input wire logic [31:0] busAddr,  // write address
    input wire logic        busError  // bus error
);
    logic [31:0] progAddr; // shadow of address bytes
    logic        trigD;    // trigger write last cycle
    // shadow the programmed target and the trigger
    always_ff @(posedge mclk) begin
        trigD <= regWrite && (regAddr == hbe_pkg::ADDR_TRIG);
        if (rst) begin
            progAddr <= 32'h0;
        end else if (regWrite) begin
            case (regAddr)
                hbe_pkg::ADDR_BYTE0: progAddr[31:24] <= regWdata;
                hbe_pkg::ADDR_BYTE1: progAddr[23:16] <= regWdata;
                hbe_pkg::ADDR_BYTE2: progAddr[15:8] <= regWdata;
                hbe_pkg::ADDR_BYTE3: progAddr[7:0] <= regWdata;
                default: progAddr <= progAddr;
            endcase
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_REQ_CAUSE: assert property ($rose(busReq) |-> trigD)
        else $error("bus request without trigger");
    AST_GRANTED: assert property (busWrite |-> busGrant && busReq)
        else $error("write without bus ownership");
    AST_BURST_TEN: assert property (
        ($rose(busWrite) && !busError) |=> busWrite [*8] ##1 busWrite ##1 !busWrite)
        else $error("burst is not ten writes");
    AST_ADDR_MAP: assert property (busWrite |-> busAddr[31:2] == progAddr[31:2])
        else $error("write address differs from programmed bytes");
    AST_ALIGN: assert property (busWrite |-> busAddr[1:0] == 2'h0)
        else $error("write address not word aligned");
    AST_SAME_ADDR: assert property ((busWrite && $past(busWrite)) |-> $stable(busAddr))
        else $error("address moved within burst");
    AST_DONE_HOLD: assert property (
        ($fell(busWrite) && !$past(busError)) |-> busReq ##1 !busReq)
        else $error("bus not held one cycle after last write");
    AST_STAT_BITS: assert property (
        (regRead && regAddr == hbe_pkg::ADDR_STATUS) |=> regRdata[6:0] == 7'h0)
        else $error("status low bits not zero");
    AST_ERR_STOP: assert property (busError |=> !busWrite)
        else $error("write after bus error");
    AST_LOG_RSVD: assert property (
        (regRead && regAddr == hbe_pkg::ADDR_ERRLOG) |=> !regRdata[7])
        else $error("reserved log bit set");
endmodule : hbe_asserts

/* File: tb/tb_top.sv */
// Purpose: bench for the burst engine driven through its ahb host
// Assumes: host sequences address, trigger, polling and done clear
// Notes:   results read back from host registers
`timescale 1ns/1ps
module tb_top;
    logic        mclk, rst, hsel, hwrite, hready, hreadyout, hresp, irq, running; // control
    logic [31:0] haddr, hwdata, hrdata, rv;  // ahb data and read value
    logic [1:0]  htrans;                     // ahb transfer type
    logic [2:0]  hsize;                      // ahb size
    logic [5:0]  masterErr;                  // other masters' errors
    logic [7:0]  errClear;                   // error log clear
    int          n_mismatch;                 // mismatch count
    int          tests_run;                  // comparison count
    logic [31:0] tAddr [3] = '{32'hA5C30F7B, 32'hFFFFFFFF, 32'h00000002}; // targets
    logic [7:0]  rOfs [7] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40}; // reset reads

    assign hready = hreadyout; // single slave
    hbe_if lnk (.mclk(mclk), .rst(rst));
    hbe_burst_engine u_hbe_burst_engine (.link(lnk), .masterErr(masterErr), .errClear(errClear),
                                         .running(running));
    hbe_bus_host u_hbe_bus_host (.link(lnk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq));
    hbe_asserts u_hbe_asserts (.mclk(mclk), .rst(rst), .regWrite(lnk.regWrite), .regRead(lnk.regRead),
        .regAddr(lnk.regAddr), .regWdata(lnk.regWdata), .regRdata(lnk.regRdata), .busReq(lnk.busReq),
        .busGrant(lnk.busGrant), .busWrite(lnk.busWrite), .busAddr(lnk.busAddr), .busError(lnk.busError));

    // clock
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one single ahb transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, ofs};
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'h1);
        rv = hrdata;
    endtask : ahb

    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
        ahb(1'h0, ofs, 32'h0);
        chk(rv, exp);
    endtask : rdchk

    // start a host sequence and poll until the wanted status appears
    task automatic go(input logic [31:0] ctrl, input logic [31:0] want);
        int k;
        ahb(1'h1, hbe_pkg::H_ISTAT, 32'h3);
        ahb(1'h1, hbe_pkg::H_WCNT, 32'h0);
        ahb(1'h1, hbe_pkg::H_CTRL, ctrl);
        k = 0;
        do begin
            ahb(1'h0, hbe_pkg::H_ISTAT, 32'h0);
            k++;
        end while (rv !== want && k < 300);
        chk(rv, want);
    endtask : go

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // watchdog
    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        $display("Error %0t: timeout", $time);
        print_verdict();
    end

    // main sequence
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rst = 1'h1;
        {hsel, hwrite, htrans, haddr, hwdata, masterErr, errClear} = '0;
        hsize = 3'h2;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        foreach (rOfs[i]) rdchk(rOfs[i], 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset values done");
        ahb(1'h1, hbe_pkg::H_IMASK, 32'h3);
        foreach (tAddr[i]) begin
            ahb(1'h1, hbe_pkg::H_TADDR, tAddr[i]);
            go(32'h1, 32'h1);
            rdchk(hbe_pkg::H_WCNT, 32'hA);
            rdchk(hbe_pkg::H_LADDR, tAddr[i] & 32'hFFFFFFFC);
            chk({31'h0, running}, 32'h0);
        end
        chk({31'h0, irq}, 32'h1);
        ahb(1'h1, hbe_pkg::H_IMASK, 32'h0);
        rdchk(hbe_pkg::H_ISTAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("test back to back runs done");
        ahb(1'h1, hbe_pkg::H_IMASK, 32'h2);
        go(32'h3, 32'h2);
        rdchk(hbe_pkg::H_ERRLOG, 32'h40);
        chk({31'h0, irq}, 32'h1);
        go(32'h1, 32'h2);
        rdchk(hbe_pkg::H_WCNT, 32'h0);
        errClear <= 8'h40;
        @(posedge mclk);
        errClear <= 8'h0;
        go(32'h1, 32'h1);
        rdchk(hbe_pkg::H_WCNT, 32'hA);
        $display("test bus error done");
        for (int i = 0; i < 6; i++) begin
            masterErr <= 6'(1 << i);
            @(posedge mclk);
            masterErr <= 6'h0;
            go(32'h1, 32'h1);
            rdchk(hbe_pkg::H_ERRLOG, 32'h1 << i);
            errClear <= 8'h3F;
            @(posedge mclk);
            errClear <= 8'h0;
        end
        $display("test other masters done");
        print_verdict();
    end
endmodule : tb_top
